// ---- hw/cfg_legality_check.sv ----
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// switch combination legality
// ****************************************
module cfg_legality_check (
  // switch fields
  input  wire logic async_sel,
  input  wire logic alt_std,
  input  wire logic clen,
  input  wire logic ovs,
  // verdict
  output logic      sync_misuse,
  output logic      alt_misuse,
  output logic      illegal
);
  // in synchronous mode these two bits select factory test modes
  assign sync_misuse = !async_sel && (clen || ovs);
  // extended lengths and wider overspeed are missing from the alternative standard
  assign alt_misuse  = alt_std && (clen || ovs);
  assign illegal     = sync_misuse || alt_misuse;
endmodule // cfg_legality_check
`default_nettype wire

// ---- hw/modem_config_ctrl.sv ----
// Added by the designer: register access over AHB-Lite and the register addresses.
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - standard switch selects V.22 or alternative
// - scrambler switch drives scrambler enable
// - answer tone switch permits answer tone
// - telephone/data switch selects line path
// - remote loop switch sends loop request
// - loop request only after synchronization
// - send loop cancel when switch returns
// - auto answer switch enables answering
// - sync mode forces length, overspeed zero
// - alternative standard forbids extended settings
// - illegal combination detected and user alerted
// - transmit disable switch inhibits data
// - rate select chooses high or low rate
module modem_config_ctrl #(
  parameter int BREAK_CYCLES = modem_cfg_pkg::BREAK_CYC,
  parameter int MAKE_CYCLES  = modem_cfg_pkg::MAKE_CYC
) (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // configuration switches and line status
  input  wire logic [15:0] config_switch,
  input  wire logic        ring_detect,
  // datapump mode inputs
  output logic             rate_select,
  output logic             alt_standard,
  output logic             guard_tone_enable,
  output logic             scrambler_enable,
  output logic             answer_mode,
  output logic             answer_tone_enable,
  output logic             auto_answer_enable,
  output logic             async_select,
  output logic             format_select,
  output logic             char_length_extend,
  output logic             overspeed_enable,
  output logic             tx_disable,
  output logic             remote_loop_request,
  output logic             loop_cancel,
  // line interface
  output logic             data_path_select,
  output logic             line_loop_closed,
  output logic             config_alert
);
  // ****************************************
  // states and storage
  // ****************************************
  typedef enum logic [1:0] {S_IDLE, S_CHECK, S_ONLINE, S_ALERT} main_e;
  typedef enum logic [1:0] {D_IDLE, D_BREAK, D_MAKE} dial_e;

  main_e                         state_q, state_d;
  dial_e                         dstate_q, dstate_d;
  logic [15:0]                   sw_q;
  logic [31:0]                   ctrl_q;
  logic [2:0]                    event_q;
  logic [13:1]                   mode_q;
  logic                          loop_q;
  logic                          cancel_q;
  logic                          closed_q;
  logic [3:0]                    digits_q;
  logic [modem_cfg_pkg::TIMER_W-1:0] timer_q;
  logic [7:0]                    addr_q;
  logic                          wr_q;
  logic [31:0]                   rdata_q;

  // ****************************************
  // bus slave
  // ****************************************
  wire        bus_take    = hsel && htrans[1] && hready;
  wire        wr_ctrl     = wr_q && (addr_q == modem_cfg_pkg::CTRL_OFS);
  wire        wr_dial     = wr_q && (addr_q == modem_cfg_pkg::DIAL_OFS);
  wire        wr_event    = wr_q && (addr_q == modem_cfg_pkg::EVENT_OFS);
  wire [7:0]  rd_addr     = haddr[7:0];
  wire [31:0] status_word;
  wire [31:0] rd_mux;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = rdata_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_q  <= 8'h00;
      wr_q    <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      wr_q    <= bus_take && hwrite;
      addr_q  <= bus_take ? rd_addr : addr_q;
      rdata_q <= (bus_take && !hwrite) ? rd_mux : rdata_q;
    end
  end

  assign rd_mux = (rd_addr == modem_cfg_pkg::CTRL_OFS)   ? ctrl_q :
                  (rd_addr == modem_cfg_pkg::STATUS_OFS) ? status_word :
                  (rd_addr == modem_cfg_pkg::SWITCH_OFS) ? {16'h0000, sw_q} :
                  (rd_addr == modem_cfg_pkg::DIAL_OFS)   ? {28'h000_0000, digits_q} :
                  (rd_addr == modem_cfg_pkg::EVENT_OFS)  ? {29'h0000_0000, event_q} :
                  32'h0000_0000;

  // ****************************************
  // switch sampling and legality
  // ****************************************
  logic illegal;

  cfg_legality_check u_check (
    .async_sel   (sw_q[modem_cfg_pkg::SW_ASYNC]),
    .alt_std     (sw_q[modem_cfg_pkg::SW_ALT_STD]),
    .clen        (sw_q[modem_cfg_pkg::SW_CLEN]),
    .ovs         (sw_q[modem_cfg_pkg::SW_OVERSPEED]),
    .sync_misuse (),
    .alt_misuse  (),
    .illegal     (illegal)
  );

  // settings only follow the switches while idle, so a connection never sees them move
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) sw_q <= modem_cfg_pkg::SW_RESET;
    else if (state_q == S_IDLE) sw_q <= config_switch;
  end

  // ****************************************
  // control register and connection sequencing
  // ****************************************
  wire synced      = ctrl_q[modem_cfg_pkg::CTRL_SYNCED];
  wire auto_pickup = (state_q == S_IDLE) && ring_detect && sw_q[modem_cfg_pkg::SW_AUTO_ANS];
  wire hangup      = !ctrl_q[modem_cfg_pkg::CTRL_CONNECT];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= modem_cfg_pkg::CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_q <= {30'h0000_0000, hwdata[1:0]};
    end else if (auto_pickup) begin
      ctrl_q[modem_cfg_pkg::CTRL_CONNECT] <= 1'b1;
    end else if (state_q == S_IDLE) begin
      ctrl_q[modem_cfg_pkg::CTRL_SYNCED] <= 1'b0;
    end
  end

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      S_IDLE:   if (!hangup) state_d = S_CHECK;
      S_CHECK:  state_d = illegal ? S_ALERT : S_ONLINE;
      S_ONLINE: if (hangup) state_d = S_IDLE;
      S_ALERT:  if (hangup) state_d = S_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) state_q <= S_IDLE;
    else state_q <= state_d;
  end

  // ****************************************
  // datapump mode outputs
  // ****************************************
  wire alt       = sw_q[modem_cfg_pkg::SW_ALT_STD];
  wire ans       = sw_q[modem_cfg_pkg::SW_ANSWER];
  wire async_m   = sw_q[modem_cfg_pkg::SW_ASYNC];
  // answer sends in the upper channel; guard tone exists only in V.22
  wire guard_d   = !alt && ans && sw_q[modem_cfg_pkg::SW_GUARD];
  // illegal bits are never passed on, so the pump cannot fall into test modes
  wire clen_d    = async_m && !alt && sw_q[modem_cfg_pkg::SW_CLEN];
  wire ovs_d     = async_m && !alt && sw_q[modem_cfg_pkg::SW_OVERSPEED];
  wire [13:1] mode_d = {sw_q[modem_cfg_pkg::SW_DATA],
                        sw_q[modem_cfg_pkg::SW_TX_OFF],
                        ovs_d,
                        clen_d,
                        async_m && sw_q[modem_cfg_pkg::SW_FORMAT],
                        async_m,
                        sw_q[modem_cfg_pkg::SW_AUTO_ANS],
                        sw_q[modem_cfg_pkg::SW_ANS_TONE],
                        ans,
                        sw_q[modem_cfg_pkg::SW_SCRAMBLE],
                        guard_d,
                        alt,
                        sw_q[modem_cfg_pkg::SW_RATE]};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) mode_q <= 13'h0000;
    else mode_q <= mode_d;
  end

  assign rate_select        = mode_q[1];
  assign alt_standard       = mode_q[2];
  assign guard_tone_enable  = mode_q[3];
  assign scrambler_enable   = mode_q[4];
  assign answer_mode        = mode_q[5];
  assign answer_tone_enable = mode_q[6];
  assign auto_answer_enable = mode_q[7];
  assign async_select       = mode_q[8];
  assign format_select      = mode_q[9];
  assign char_length_extend = mode_q[10];
  assign overspeed_enable   = mode_q[11];
  assign tx_disable         = mode_q[12];
  assign data_path_select   = mode_q[13];

  // ****************************************
  // remote digital loop
  // ****************************************
  // the switch is read live: the loop is requested and released during a call
  wire loop_sw    = config_switch[modem_cfg_pkg::SW_RLOOP];
  wire online     = state_q == S_ONLINE;
  wire loop_d     = online && synced && loop_sw;
  wire cancel_d   = loop_q && !loop_d;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      loop_q   <= 1'b0;
      cancel_q <= 1'b0;
    end else begin
      loop_q   <= loop_d;
      cancel_q <= cancel_d;
    end
  end

  assign remote_loop_request = loop_q;
  assign loop_cancel         = cancel_q;

  // ****************************************
  // pulse dialing
  // ****************************************
  wire dial_start = wr_dial && online && (dstate_q == D_IDLE) &&
                    (hwdata[3:0] != 4'h0) && (hwdata[3:0] <= modem_cfg_pkg::DIAL_MAX);
  wire timer_done = timer_q == '0;

  always_comb begin
    dstate_d = dstate_q;
    unique case (dstate_q)
      D_IDLE:  if (dial_start) dstate_d = D_BREAK;
      D_BREAK: if (!online) dstate_d = D_IDLE;
               else if (timer_done) dstate_d = D_MAKE;
      D_MAKE:  if (!online || (timer_done && digits_q == 4'h1)) dstate_d = D_IDLE;
               else if (timer_done) dstate_d = D_BREAK;
      default: dstate_d = D_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dstate_q <= D_IDLE;
      digits_q <= 4'h0;
      timer_q  <= '0;
    end else begin
      dstate_q <= dstate_d;
      if (dial_start) begin
        digits_q <= hwdata[3:0];
        timer_q  <= modem_cfg_pkg::TIMER_W'(BREAK_CYCLES - 1);
      end else if (dstate_d == D_IDLE) begin
        digits_q <= 4'h0;
        timer_q  <= '0;
      end else if (dstate_q == D_BREAK && dstate_d == D_MAKE) begin
        timer_q  <= modem_cfg_pkg::TIMER_W'(MAKE_CYCLES - 1);
      end else if (dstate_q == D_MAKE && dstate_d == D_BREAK) begin
        digits_q <= digits_q - 4'h1;
        timer_q  <= modem_cfg_pkg::TIMER_W'(BREAK_CYCLES - 1);
      end else begin
        timer_q  <= timer_q - 1'b1;
      end
    end
  end

  // loop is opened for each break pulse, closed otherwise while on line
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) closed_q <= 1'b0;
    else closed_q <= online && (dstate_d != D_BREAK);
  end

  assign line_loop_closed = closed_q;
  assign config_alert     = state_q == S_ALERT;

  // ****************************************
  // events and status
  // ****************************************
  wire [2:0] ev_set = {cancel_q, state_q == S_CHECK && illegal, ring_detect};
  wire [2:0] ev_clr = wr_event ? hwdata[2:0] : 3'h0;

  // a new event wins over a clear in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) event_q <= 3'h0;
    else event_q <= (event_q & ~ev_clr) | ev_set;
  end

  assign status_word = {26'h000_0000, loop_q, dstate_q != D_IDLE, state_q == S_ALERT,
                        online, illegal, ring_detect};

  // ****************************************
  // checks
  // ****************************************
  a_guard_upper: assert property (@(posedge hclk) disable iff (!hresetn)
    guard_tone_enable |-> (answer_mode && !alt_standard))
    else $error("guard tone outside V.22 upper channel");

  a_guard_lower: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_q == S_ONLINE && !sw_q[modem_cfg_pkg::SW_GUARD]) |-> ##1 !guard_tone_enable)
    else $error("guard tone while switch off");

  a_sync_bits_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    !async_select |-> (!char_length_extend && !overspeed_enable))
    else $error("test mode bits driven in synchronous mode");

  a_alt_no_ext: assert property (@(posedge hclk) disable iff (!hresetn)
    alt_standard |-> !(char_length_extend || overspeed_enable))
    else $error("extended setting in alternative standard");

  a_loop_after_sync: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(remote_loop_request) |-> $past(synced) && $past(state_q == S_ONLINE))
    else $error("loop request before synchronization");

  a_cancel_follows: assert property (@(posedge hclk) disable iff (!hresetn)
    $fell(remote_loop_request) |-> loop_cancel ##1 !loop_cancel)
    else $error("loop cancel not a single pulse after release");

  a_illegal_alert: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_q == S_CHECK && illegal) |=> config_alert && !line_loop_closed)
    else $error("illegal settings not alerted");

  a_online_legal: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(state_q == S_ONLINE) |-> !illegal ##1 line_loop_closed)
    else $error("went on line with illegal settings");

  a_ring_sticky: assert property (@(posedge hclk) disable iff (!hresetn)
    ring_detect |=> event_q[modem_cfg_pkg::EV_RING])
    else $error("ring event lost");

  a_dial_break: assert property (@(posedge hclk) disable iff (!hresetn)
    (dstate_q == D_BREAK) |-> !line_loop_closed)
    else $error("loop not opened during dial break");
endmodule // modem_config_ctrl
`default_nettype wire

// ---- inc/modem_cfg_pkg.sv ----
`default_nettype none
package modem_cfg_pkg;
  // ****************************************
  // register map of the controller (byte offsets on the bus)
  // ****************************************
  localparam logic [7:0]  CTRL_OFS    = 8'h00;
  localparam logic [7:0]  STATUS_OFS  = 8'h04;
  localparam logic [7:0]  SWITCH_OFS  = 8'h08;
  localparam logic [7:0]  DIAL_OFS    = 8'h0c;
  localparam logic [7:0]  EVENT_OFS   = 8'h10;

  // control register fields
  localparam int CTRL_CONNECT = 0;
  localparam int CTRL_SYNCED  = 1;
  // event register fields (write one to clear)
  localparam int EV_RING      = 0;
  localparam int EV_ILLEGAL   = 1;
  localparam int EV_CANCEL    = 2;
  // status register fields
  localparam int ST_RING      = 0;
  localparam int ST_ILLEGAL   = 1;
  localparam int ST_ONLINE    = 2;
  localparam int ST_ALERT     = 3;
  localparam int ST_DIALING   = 4;
  localparam int ST_LOOP      = 5;

  // ****************************************
  // configuration switch positions
  // ****************************************
  localparam int SW_RATE      = 0;
  localparam int SW_LOOP2     = 1;
  localparam int SW_LOOP3     = 2;
  localparam int SW_ALT_STD   = 3;
  localparam int SW_GUARD     = 4;
  localparam int SW_SCRAMBLE  = 5;
  localparam int SW_ANSWER    = 6;
  localparam int SW_ANS_TONE  = 7;
  localparam int SW_DATA      = 8;
  localparam int SW_RLOOP     = 9;
  localparam int SW_AUTO_ANS  = 10;
  localparam int SW_ASYNC     = 11;
  localparam int SW_FORMAT    = 12;
  localparam int SW_CLEN      = 13;
  localparam int SW_OVERSPEED = 14;
  localparam int SW_TX_OFF    = 15;

  localparam logic [15:0] SW_RESET    = 16'h0000;
  localparam logic [31:0] CTRL_RESET  = 32'h0000_0000;

  // ****************************************
  // pulse dialing timing
  // ****************************************
  localparam int CLK_KHZ      = 250000;
  localparam int BREAK_MS     = 60;
  localparam int MAKE_MS      = 40;
  localparam int BREAK_CYC    = BREAK_MS * CLK_KHZ;
  localparam int MAKE_CYC     = MAKE_MS * CLK_KHZ;
  localparam int TIMER_W      = 24;
  localparam logic [3:0] DIAL_MAX = 4'ha;
endpackage
`default_nettype wire

// ---- tb/datapump_line_model.sv ----
`timescale 1ns/100ps
`default_nettype none
// ****
// datapump mode decode and line interface
// ****
module datapump_line_model (
  // clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // mode inputs from the controller
  input  wire logic       guard_tone_enable,
  input  wire logic       answer_mode,
  input  wire logic       alt_standard,
  input  wire logic       async_select,
  input  wire logic       format_select,
  input  wire logic       char_length_extend,
  input  wire logic       overspeed_enable,
  input  wire logic       line_loop_closed,
  // line stimulus and observation
  input  wire logic       ring_in,
  input  wire logic       count_clr,
  output logic            ring_detect,
  output logic            guard_on,
  output logic            tx_upper,
  output logic [3:0]      char_bits,
  output logic [4:0]      tol_plus_x10,
  output logic [7:0]      break_count,
  output logic [7:0]      last_break
);
  logic [7:0] low_q;
  logic       loop_q;
  // answer sends upper, receive takes the other channel
  assign tx_upper = answer_mode;
  assign guard_on = guard_tone_enable & tx_upper & ~alt_standard;
  assign char_bits = async_select ? 4'h8 + {3'h0, format_select} + {3'h0, char_length_extend} : 4'h0;
  assign tol_plus_x10 = overspeed_enable ? 5'h17 : 5'h0a;
  assign ring_detect = ring_in;
  // a break is counted per falling edge of the loop, its length in cycles low
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      loop_q <= 1'b0;
      low_q <= 8'h00;
      break_count <= 8'h00;
      last_break <= 8'h00;
    end else begin
      loop_q <= line_loop_closed;
      if (count_clr) begin
        break_count <= 8'h00;
        last_break <= 8'h00;
      end else if (loop_q && !line_loop_closed) begin
        break_count <= break_count + 8'h01;
      end else if (!loop_q && line_loop_closed) begin
        last_break <= low_q;
      end
      low_q <= line_loop_closed ? 8'h00 : low_q + 8'h01;
    end
  end
endmodule // datapump_line_model
`default_nettype wire

// ---- tb/test_modem_config_ctrl.sv ----
`timescale 1ns/100ps
`default_nettype none
module test_modem_config_ctrl;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [15:0] sw = 16'h0000;
  logic ring_in = 1'b0;
  logic count_clr = 1'b0;
  logic hreadyout, hresp, ring_detect, guard_on, tx_upper;
  logic [31:0] hrdata;
  logic rate_select, alt_standard, guard_tone_enable, scrambler_enable, answer_mode, answer_tone_enable;
  logic auto_answer_enable, async_select, format_select, char_length_extend, overspeed_enable, tx_disable;
  logic remote_loop_request, loop_cancel, data_path_select, line_loop_closed, config_alert;
  logic [3:0] char_bits;
  logic [4:0] tol_plus_x10;
  logic [7:0] break_count, last_break;
  logic [12:0] outs;
  int err_total = 0;
  int comparisons = 0;
  int cycles = 0;

  assign outs = {rate_select, alt_standard, guard_tone_enable, scrambler_enable, answer_mode, answer_tone_enable,
                 auto_answer_enable, async_select, format_select, char_length_extend, overspeed_enable,
                 tx_disable, data_path_select};

  modem_config_ctrl #(.BREAK_CYCLES(8), .MAKE_CYCLES(5)) u_modem_config_ctrl (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .config_switch(sw), .ring_detect(ring_detect), .rate_select(rate_select),
    .alt_standard(alt_standard), .guard_tone_enable(guard_tone_enable), .scrambler_enable(scrambler_enable),
    .answer_mode(answer_mode), .answer_tone_enable(answer_tone_enable), .auto_answer_enable(auto_answer_enable),
    .async_select(async_select), .format_select(format_select), .char_length_extend(char_length_extend),
    .overspeed_enable(overspeed_enable), .tx_disable(tx_disable), .remote_loop_request(remote_loop_request),
    .loop_cancel(loop_cancel), .data_path_select(data_path_select), .line_loop_closed(line_loop_closed),
    .config_alert(config_alert));

  datapump_line_model u_datapump_line_model (
    .hclk(hclk), .hresetn(hresetn), .guard_tone_enable(guard_tone_enable), .answer_mode(answer_mode),
    .alt_standard(alt_standard), .async_select(async_select), .format_select(format_select),
    .char_length_extend(char_length_extend), .overspeed_enable(overspeed_enable),
    .line_loop_closed(line_loop_closed), .ring_in(ring_in), .count_clr(count_clr),
    .ring_detect(ring_detect), .guard_on(guard_on), .tx_upper(tx_upper), .char_bits(char_bits),
    .tol_plus_x10(tol_plus_x10), .break_count(break_count), .last_break(last_break));

  always #2 hclk = ~hclk;

  // ****
  // shared tasks
  // ****
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // the ceiling is far above the few hundred cycles the tests need
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      test_done();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge hclk);
  endtask

  // one single transfer; entered right after a rising edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    bus(1'b0, a, 32'h0, d);
  endtask

  task automatic wait_st(input int idx, input logic v);
    logic [31:0] s;
    int n;
    n = 0;
    do begin
      rd(modem_cfg_pkg::STATUS_OFS, s);
      n++;
    end while (s[idx] !== v && n < 60);
    check({31'h0, s[idx]}, {31'h0, v});
  endtask

  task automatic go_online(input logic [15:0] s);
    sw <= s;
    tick(3);
    wr(modem_cfg_pkg::CTRL_OFS, 32'h1);
    wait_st(modem_cfg_pkg::ST_ONLINE, 1'b1);
  endtask

  task automatic hang_up;
    wr(modem_cfg_pkg::CTRL_OFS, 32'h0);
    wr(modem_cfg_pkg::EVENT_OFS, 32'h7);
    tick(3);
  endtask

  // ****
  // scenarios
  // ****
  task automatic t_modes;
    logic [15:0] s_t [2] = '{16'hfdf1, 16'h1808};
    logic [12:0] o_t [2] = '{13'h17ff, 13'h0830};
    logic [31:0] r;
    for (int i = 0; i < 2; i++) begin
      sw <= s_t[i];
      tick(3);
      rd(modem_cfg_pkg::SWITCH_OFS, r);
      check(r, {16'h0, s_t[i]});
      check({19'h0, outs}, {19'h0, o_t[i]});
      check({31'h0, guard_on}, {31'h0, i == 0});
      check({31'h0, tx_upper}, {31'h0, i == 0});
      check({28'h0, char_bits}, (i == 0) ? 32'ha : 32'h9);
      check({27'h0, tol_plus_x10}, (i == 0) ? 32'h17 : 32'h0a);
    end
    rd(8'h20, r);
    check(r, 32'h0);
    go_online(16'hfdf1);
    check({31'h0, line_loop_closed}, 32'h1);
    hang_up();
    $display("test modes done");
  endtask

  task automatic t_illegal;
    logic [15:0] s_t [2] = '{16'h2000, 16'h4808};
    logic [12:0] o_t [2] = '{13'h0000, 13'h0820};
    logic [31:0] r;
    for (int i = 0; i < 2; i++) begin
      sw <= s_t[i];
      tick(3);
      check({19'h0, outs}, {19'h0, o_t[i]});
      wr(modem_cfg_pkg::CTRL_OFS, 32'h1);
      wait_st(modem_cfg_pkg::ST_ALERT, 1'b1);
      check({30'h0, config_alert, line_loop_closed}, 32'h2);
      rd(modem_cfg_pkg::EVENT_OFS, r);
      check({31'h0, r[modem_cfg_pkg::EV_ILLEGAL]}, 32'h1);
      hang_up();
    end
    $display("test illegal done");
  endtask

  task automatic t_loop;
    logic [31:0] r;
    int n;
    go_online(16'h1808);
    sw <= 16'h1a08;
    tick(6);
    check({31'h0, remote_loop_request}, 32'h0);
    wr(modem_cfg_pkg::CTRL_OFS, 32'h3);
    tick(3);
    check({31'h0, remote_loop_request}, 32'h1);
    sw <= 16'h1808;
    n = 0;
    repeat (6) begin
      @(posedge hclk);
      n += int'(loop_cancel);
    end
    check(n, 1);
    check({31'h0, remote_loop_request}, 32'h0);
    rd(modem_cfg_pkg::EVENT_OFS, r);
    check({31'h0, r[modem_cfg_pkg::EV_CANCEL]}, 32'h1);
    hang_up();
    $display("test loop done");
  endtask

  task automatic t_dial;
    logic [31:0] d_t [2] = '{32'h0, 32'hb};
    go_online(16'h1808);
    count_clr <= 1'b1;
    tick(1);
    count_clr <= 1'b0;
    wr(modem_cfg_pkg::DIAL_OFS, 32'h3);
    wait_st(modem_cfg_pkg::ST_DIALING, 1'b0);
    check({24'h0, break_count}, 32'h3);
    check({24'h0, last_break}, 32'h8);
    for (int i = 0; i < 2; i++) begin
      wr(modem_cfg_pkg::DIAL_OFS, d_t[i]);
      tick(20);
      check({24'h0, break_count}, 32'h3);
    end
    hang_up();
    $display("test dial done");
  endtask

  task automatic t_ring;
    logic [31:0] r;
    sw <= 16'h0c00;
    tick(3);
    ring_in <= 1'b1;
    tick(4);
    ring_in <= 1'b0;
    wait_st(modem_cfg_pkg::ST_ONLINE, 1'b1);
    rd(modem_cfg_pkg::EVENT_OFS, r);
    check({31'h0, r[modem_cfg_pkg::EV_RING]}, 32'h1);
    hang_up();
    $display("test ring done");
  endtask

  initial begin
    tick(5);
    check({17'h0, outs, config_alert, line_loop_closed}, 32'h0);
    check({30'h0, hreadyout, hresp}, 32'h2);
    tick(1);
    hresetn <= 1'b1;
    tick(1);
    t_modes();
    t_illegal();
    t_loop();
    t_dial();
    t_ring();
    test_done();
  end
endmodule // test_modem_config_ctrl
`default_nettype wire
